// ### inc/cursor_pkg.sv
// ==========================================================================
// shared widths and reset values of the cursor generator
package cursor_pkg;
  localparam int POS_W = 10;
  localparam int VSIZE_W = 8;
  localparam int HSIZE_W = 8;
  localparam int LOW_BITS = 4;
  localparam logic [LOW_BITS-1:0] NO_WIDEN = 4'h0;
  localparam logic [POS_W-1:0] POS_RESET = 10'h000;
  localparam logic [VSIZE_W-1:0] VSIZE_RESET = 8'h00;
  localparam logic [HSIZE_W-1:0] HSIZE_RESET = 8'h00;
endpackage

// ### inc/boundary_if.sv
`timescale 1ns/100ps
// ==========================================================================
// one boundary compare: a counter value against a target word
interface boundary_if #(parameter int W = 10);
  logic [W-1:0] count_val;
  logic [W-1:0] target_val;
  logic hit;
  modport cmp (input count_val, input target_val, output hit);
  modport user (output count_val, output target_val, input hit);
endinterface // boundary_if

// ### logic/boundary_compare.sv
`timescale 1ns/100ps
// ==========================================================================
// equality compare whose low bits may be forced equal to widen a boundary
module boundary_compare #(
  parameter int W = 10,
  parameter logic [cursor_pkg::LOW_BITS-1:0] WIDEN = cursor_pkg::NO_WIDEN
) (
  // compare bus
  boundary_if.cmp bus
);
  import cursor_pkg::*;

  logic [W-1:0] care;

  // a set widen bit drops that bit out of the compare
  assign care = ~{{(W-LOW_BITS){1'b0}}, WIDEN};
  assign bus.hit = ((bus.count_val ^ bus.target_val) & care) == '0;

endmodule // boundary_compare

// ### logic/raster_cursor_generator.sv
`timescale 1ns/100ps
// Behaviour
// - row pulses are counted in plain sequence, so rows X and X+1 are neighbours.
// - the row counter clears on the frame pulse, steps on row pulses, and its match is the top edge.
// - the top match opens the vertical window during the requested row itself.
// - in the window a size counter counts rows, its match is the bottom edge, and the window closes after it.
// - the size counter against the size word halved gives the horizontal crosshair row.
// - horizontal counters clear on the row pulse and step on dot ticks to give left, right and vertical crosshair.
// - horizontal compares work only inside the vertical window, giving the inside-box signal.
// - the outline is the OR of four edges ANDed with inside-box, passed when selected.
// - the crosshair is horizontal crosshair AND inside-box, OR vertical crosshair, passed when selected.
// - inside-box is the filled cursor, and all selected types are ORed into one output bit.
// - each comparator may force any of its four low bits equal to widen its boundary.
// - the six boundaries are widened independently.
// - widening moves the cursor centre by half the boundary width and is not compensated.
module raster_cursor_generator #(
  parameter logic [cursor_pkg::LOW_BITS-1:0] TOP_WIDEN = cursor_pkg::NO_WIDEN,
  parameter logic [cursor_pkg::LOW_BITS-1:0] BOTTOM_WIDEN = cursor_pkg::NO_WIDEN,
  parameter logic [cursor_pkg::LOW_BITS-1:0] LEFT_WIDEN = cursor_pkg::NO_WIDEN,
  parameter logic [cursor_pkg::LOW_BITS-1:0] RIGHT_WIDEN = cursor_pkg::NO_WIDEN,
  parameter logic [cursor_pkg::LOW_BITS-1:0] HCROSS_WIDEN = cursor_pkg::NO_WIDEN,
  parameter logic [cursor_pkg::LOW_BITS-1:0] VCROSS_WIDEN = cursor_pkg::NO_WIDEN
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // raster timing
  input wire logic frame_pulse_i,
  input wire logic row_pulse_i,
  input wire logic dot_tick_i,
  // cursor placement and size
  input wire logic [cursor_pkg::POS_W-1:0] vpos_i,
  input wire logic [cursor_pkg::POS_W-1:0] hpos_i,
  input wire logic [cursor_pkg::VSIZE_W-1:0] vsize_i,
  input wire logic [cursor_pkg::HSIZE_W-1:0] hsize_i,
  // cursor type selects
  input wire logic sel_outline_i,
  input wire logic sel_crosshair_i,
  input wire logic sel_fill_i,
  // video overlay
  output logic cursor_o
);
  import cursor_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [POS_W-1:0] row_cnt;
    logic [VSIZE_W-1:0] vsize_cnt;
    logic vwin;
    logic [POS_W-1:0] dot_cnt;
    logic [HSIZE_W-1:0] hsize_cnt;
    logic hwin;
    logic cursor;
  } state_type;

  localparam state_type STATE_RESET = '{
    row_cnt: POS_RESET, vsize_cnt: VSIZE_RESET, vwin: 1'b0,
    dot_cnt: POS_RESET, hsize_cnt: HSIZE_RESET, hwin: 1'b0, cursor: 1'b0};

  state_type st;
  state_type next_st;

  // ==========================================================================
  // boundary comparators
  boundary_if #(.W(POS_W)) top_bus ();
  boundary_if #(.W(VSIZE_W)) bottom_bus ();
  boundary_if #(.W(VSIZE_W)) bottom_next_bus ();
  boundary_if #(.W(VSIZE_W)) hcross_bus ();
  boundary_if #(.W(POS_W)) left_bus ();
  boundary_if #(.W(HSIZE_W)) right_bus ();
  boundary_if #(.W(HSIZE_W)) right_next_bus ();
  boundary_if #(.W(HSIZE_W)) vcross_bus ();

  assign top_bus.count_val = st.row_cnt;
  assign top_bus.target_val = vpos_i;
  assign bottom_bus.count_val = st.vsize_cnt;
  assign bottom_bus.target_val = vsize_i;
  assign bottom_next_bus.count_val = st.vsize_cnt + VSIZE_W'(1);
  assign bottom_next_bus.target_val = vsize_i;
  // size word slipped one bit toward the low end lands midway
  assign hcross_bus.count_val = st.vsize_cnt;
  assign hcross_bus.target_val = {1'b0, vsize_i[VSIZE_W-1:1]};
  assign left_bus.count_val = st.dot_cnt;
  assign left_bus.target_val = hpos_i;
  assign right_bus.count_val = st.hsize_cnt;
  assign right_bus.target_val = hsize_i;
  assign right_next_bus.count_val = st.hsize_cnt + HSIZE_W'(1);
  assign right_next_bus.target_val = hsize_i;
  assign vcross_bus.count_val = st.hsize_cnt;
  assign vcross_bus.target_val = {1'b0, hsize_i[HSIZE_W-1:1]};

  // each boundary carries its own mask; centre shift is left to the host
  boundary_compare #(.W(POS_W), .WIDEN(TOP_WIDEN)) top_cmp (.bus(top_bus));
  boundary_compare #(.W(VSIZE_W), .WIDEN(BOTTOM_WIDEN)) bottom_cmp (.bus(bottom_bus));
  boundary_compare #(.W(VSIZE_W), .WIDEN(BOTTOM_WIDEN)) bottom_next_cmp (
    .bus(bottom_next_bus)
  );
  boundary_compare #(.W(VSIZE_W), .WIDEN(HCROSS_WIDEN)) hcross_cmp (.bus(hcross_bus));
  boundary_compare #(.W(POS_W), .WIDEN(LEFT_WIDEN)) left_cmp (.bus(left_bus));
  boundary_compare #(.W(HSIZE_W), .WIDEN(RIGHT_WIDEN)) right_cmp (.bus(right_bus));
  boundary_compare #(.W(HSIZE_W), .WIDEN(RIGHT_WIDEN)) right_next_cmp (
    .bus(right_next_bus)
  );
  boundary_compare #(.W(HSIZE_W), .WIDEN(VCROSS_WIDEN)) vcross_cmp (
    .bus(vcross_bus)
  );

  // ==========================================================================
  // boundary signals
  logic top;
  logic in_vwin;
  logic bottom;
  logic hcross;
  logic left;
  logic in_hwin;
  logic right;
  logic vcross;
  logic area;
  logic outline_pix;
  logic cross_pix;
  logic next_cursor;
  logic v_close;
  logic h_close;

  // top row opens the window at once, so the requested row is covered
  assign top = top_bus.hit;
  assign in_vwin = st.vwin | top;
  assign bottom = in_vwin & bottom_bus.hit;
  assign hcross = in_vwin & hcross_bus.hit;
  // horizontal matches count only inside the vertical window; the dot counter runs always
  assign left = in_vwin & left_bus.hit;
  assign in_hwin = in_vwin & (st.hwin | left);
  assign right = in_hwin & right_bus.hit;
  assign vcross = in_hwin & vcross_bus.hit;
  assign area = in_vwin & in_hwin;
  // closing beats a top or left match, so a zero size still spans one row or dot
  assign v_close = row_pulse_i & bottom & ~bottom_next_bus.hit;
  assign h_close = dot_tick_i & right & ~right_next_bus.hit;

  assign outline_pix = (top | bottom | left | right) & area;
  assign cross_pix = (hcross & area) | vcross;
  assign next_cursor = (sel_outline_i & outline_pix)
    | (sel_crosshair_i & cross_pix)
    | (sel_fill_i & area);

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.cursor = next_cursor;
    // vertical chain
    if (frame_pulse_i) begin
      next_st.row_cnt = POS_RESET;
      next_st.vsize_cnt = VSIZE_RESET;
      next_st.vwin = 1'b0;
    end else begin
      if (row_pulse_i) begin
        next_st.row_cnt = st.row_cnt + POS_W'(1);
      end
      if (!in_vwin) begin
        next_st.vsize_cnt = VSIZE_RESET;
      end else if (row_pulse_i) begin
        next_st.vsize_cnt = st.vsize_cnt + VSIZE_W'(1);
      end
      // window closes at the end of the last bottom row
      if (v_close) begin
        next_st.vwin = 1'b0;
      end else if (top) begin
        next_st.vwin = 1'b1;
      end
    end
    // horizontal chain
    if (row_pulse_i || frame_pulse_i) begin
      next_st.dot_cnt = POS_RESET;
      next_st.hsize_cnt = HSIZE_RESET;
      next_st.hwin = 1'b0;
    end else begin
      if (dot_tick_i) begin
        next_st.dot_cnt = st.dot_cnt + POS_W'(1);
      end
      if (!in_hwin) begin
        next_st.hsize_cnt = HSIZE_RESET;
      end else if (dot_tick_i) begin
        next_st.hsize_cnt = st.hsize_cnt + HSIZE_W'(1);
      end
      if (h_close) begin
        next_st.hwin = 1'b0;
      end else if (left) begin
        next_st.hwin = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cursor_o = st.cursor;

  // ==========================================================================
  // checks
  default clocking chk_clk @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ROW_CLEAR: assert property (frame_pulse_i |=> st.row_cnt == POS_RESET)
    else $error("row counter not cleared by frame pulse");
  AST_ROW_STEP: assert property (
    row_pulse_i && !frame_pulse_i |=> st.row_cnt == POS_W'($past(st.row_cnt) + 1))
    else $error("row counter did not step by one");
  AST_ROW_HOLD: assert property (
    !row_pulse_i && !frame_pulse_i |=> $stable(st.row_cnt))
    else $error("row counter moved without a row pulse");
  AST_TOP_OPENS: assert property (
    top && !frame_pulse_i && !v_close |=> st.vwin)
    else $error("top match did not open the vertical window");
  AST_BOTTOM_CLOSES: assert property (
    v_close && !frame_pulse_i |=> !st.vwin)
    else $error("window stayed open after the bottom row");
  AST_SIZE_IDLE: assert property (!in_vwin |=> st.vsize_cnt == VSIZE_RESET)
    else $error("size counter ran outside the window");
  AST_FRAME_CLOSES: assert property (
    frame_pulse_i |=> !st.vwin && st.vsize_cnt == VSIZE_RESET)
    else $error("frame pulse left the vertical window open");
  AST_VWIN_HOLD: assert property (
    st.vwin && !frame_pulse_i && !row_pulse_i |=> st.vwin)
    else $error("vertical window closed inside a row");
  AST_VSIZE_STEP: assert property (
    in_vwin && row_pulse_i && !frame_pulse_i |=>
      st.vsize_cnt == VSIZE_W'($past(st.vsize_cnt) + 1))
    else $error("size counter did not step by one");
  AST_VSIZE_HOLD: assert property (
    in_vwin && !row_pulse_i && !frame_pulse_i |=> $stable(st.vsize_cnt))
    else $error("size counter moved without a row pulse");
  AST_DOT_CLEAR: assert property (row_pulse_i |=> st.dot_cnt == POS_RESET)
    else $error("dot counter not cleared by row pulse");
  AST_HORIZ_GATED: assert property (st.hwin |-> in_vwin)
    else $error("horizontal boundary outside the vertical window");

  // ==========================================================================
  // horizontal chain and output checks
  AST_DOT_STEP: assert property (
    dot_tick_i && !row_pulse_i && !frame_pulse_i |=>
      st.dot_cnt == POS_W'($past(st.dot_cnt) + 1))
    else $error("dot counter did not step by one");
  AST_DOT_HOLD: assert property (
    !dot_tick_i && !row_pulse_i && !frame_pulse_i |=> $stable(st.dot_cnt))
    else $error("dot counter moved without a dot tick");
  AST_FRAME_DOTS: assert property (frame_pulse_i |=> st.dot_cnt == POS_RESET)
    else $error("dot counter not cleared by frame pulse");
  AST_HWIN_CLEAR: assert property (
    row_pulse_i || frame_pulse_i |=> !st.hwin && st.hsize_cnt == HSIZE_RESET)
    else $error("row pulse left the horizontal window open");
  AST_LEFT_OPENS: assert property (
    left && !h_close && !row_pulse_i && !frame_pulse_i |=> st.hwin)
    else $error("left match did not open the horizontal window");
  AST_RIGHT_CLOSES: assert property (
    h_close && !row_pulse_i && !frame_pulse_i |=> !st.hwin)
    else $error("window stayed open after the right edge");
  AST_HSIZE_STEP: assert property (
    in_hwin && dot_tick_i && !row_pulse_i && !frame_pulse_i |=>
      st.hsize_cnt == HSIZE_W'($past(st.hsize_cnt) + 1))
    else $error("width counter did not step by one");
  AST_HSIZE_IDLE: assert property (!in_hwin |=> st.hsize_cnt == HSIZE_RESET)
    else $error("width counter ran outside the window");
  AST_FILL_OUT: assert property (sel_fill_i && area |=> cursor_o)
    else $error("filled cursor not on the output");
  AST_XHAIR_OUT: assert property (sel_crosshair_i && vcross |=> cursor_o)
    else $error("vertical crosshair not on the output");
  AST_OUTLINE_OUT: assert property (sel_outline_i && area && top |=> cursor_o)
    else $error("outline top edge not on the output");
  AST_NONE_SELECTED: assert property (
    !sel_outline_i && !sel_crosshair_i && !sel_fill_i |=> !cursor_o)
    else $error("cursor shown with no type selected");

  // ==========================================================================
  // output checks and covers
  AST_CROSS_OUT: assert property (
    sel_crosshair_i && hcross && area |=> cursor_o)
    else $error("horizontal crosshair not on the output");
  AST_OUTLINE_SIDES: assert property (
    sel_outline_i && area && (bottom || left || right) |=> cursor_o)
    else $error("outline side or bottom not on the output");
  AST_OUTSIDE_DARK: assert property (!area |=> !cursor_o)
    else $error("cursor shown outside the box");
  AST_OUTLINE_INNER: assert property (
    sel_outline_i && !sel_crosshair_i && !sel_fill_i && !top && !bottom && !left && !right
      |=> !cursor_o)
    else $error("outline lit inside the box");

  COV_FILL: cover property (sel_fill_i && area ##1 cursor_o);
  COV_BOTTOM_END: cover property (row_pulse_i && bottom && !bottom_next_bus.hit);
  COV_CROSS: cover property (sel_crosshair_i && hcross && area);
  COV_OUTLINE: cover property (sel_outline_i && right && area);
  COV_ZERO_SIZE: cover property (v_close && top);

endmodule // raster_cursor_generator

// ### tb/raster_timing_model.sv
`timescale 1ns/100ps
// ==========================================================================
// timing generator model: a frame pulse, then rows of spaced dot ticks
module raster_timing_model #(
  parameter int DOTS = 12
) (
  // clock and frame request
  input wire logic sys_clk_i,
  input wire logic start_i,
  input wire logic [9:0] rows_i,
  // raster timing
  output logic frame_pulse_o,
  output logic row_pulse_o,
  output logic dot_tick_o,
  // dot being shown, settled while probe_o is high
  output logic probe_o,
  output logic busy_o,
  output int row_o,
  output int dot_o
);
  initial begin
    frame_pulse_o = 1'b0;
    row_pulse_o = 1'b0;
    dot_tick_o = 1'b0;
    probe_o = 1'b0;
    busy_o = 1'b0;
    row_o = 0;
    dot_o = 0;
    forever begin
      @(posedge sys_clk_i);
      if (start_i) begin
        busy_o = 1'b1;
        @(negedge sys_clk_i);
        frame_pulse_o = 1'b1;
        @(negedge sys_clk_i);
        frame_pulse_o = 1'b0;
        for (int r = 1; r <= int'(rows_i); r++) begin
          row_o = r;
          for (int k = 0; k < DOTS; k++) begin
            // the row pulse stands for dot 0
            if (k == 0) row_pulse_o = 1'b1;
            else dot_tick_o = 1'b1;
            dot_o = k;
            @(negedge sys_clk_i);
            row_pulse_o = 1'b0;
            dot_tick_o = 1'b0;
            @(negedge sys_clk_i);
            probe_o = 1'b1;
            @(negedge sys_clk_i);
            probe_o = 1'b0;
          end
        end
        busy_o = 1'b0;
      end
    end
  end
endmodule // raster_timing_model

// ### tb/raster_cursor_generator_test.sv
`timescale 1ns/100ps
// ==========================================================================
// cursor shapes from a table, then a reset in mid-frame
module raster_cursor_generator_test;
  import cursor_pkg::*;
  typedef struct {int vp; int hp; int vs; int hs; logic [2:0] sel; int lit;} case_type;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start = 1'b0;
  logic [9:0] rows = 10'h000;
  logic [POS_W-1:0] vpos = 10'h000;
  logic [POS_W-1:0] hpos = 10'h000;
  logic [VSIZE_W-1:0] vsize = 8'h00;
  logic [HSIZE_W-1:0] hsize = 8'h00;
  logic [2:0] sel = 3'h0;
  logic frame_pulse, row_pulse, dot_tick, probe, busy, cursor_o, cursor_wide;
  int row_n, dot_n, lit, lit_wide, errors, check_count;
  // fill and outline totals of the first two rows with the top edge two rows thick
  int wide_lit[2] = '{25, 19};
  logic checking = 1'b1;
  case_type cur;
  // sel: bit 0 outline, bit 1 crosshair, bit 2 filled
  case_type table_rows[10] = '{
    '{2, 3, 4, 4, 3'h4, 25}, '{2, 3, 4, 4, 3'h1, 16}, '{2, 3, 4, 4, 3'h2, 9},
    '{2, 3, 4, 4, 3'h3, 21}, '{2, 3, 4, 4, 3'h7, 25}, '{2, 3, 4, 4, 3'h0, 0},
    '{3, 2, 3, 5, 3'h2, 9}, '{263, 4, 0, 0, 3'h4, 1}, '{5, 1, 2, 0, 3'h1, 3},
    '{1, 0, 1, 1, 3'h4, 4}};

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  raster_timing_model raster_timing_model_i (.sys_clk_i(sys_clk_i), .start_i(start),
    .rows_i(rows), .frame_pulse_o(frame_pulse), .row_pulse_o(row_pulse),
    .dot_tick_o(dot_tick), .probe_o(probe), .busy_o(busy), .row_o(row_n), .dot_o(dot_n));

  raster_cursor_generator raster_cursor_generator_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .frame_pulse_i(frame_pulse), .row_pulse_i(row_pulse), .dot_tick_i(dot_tick),
    .vpos_i(vpos), .hpos_i(hpos), .vsize_i(vsize), .hsize_i(hsize),
    .sel_outline_i(sel[0]), .sel_crosshair_i(sel[1]), .sel_fill_i(sel[2]),
    .cursor_o(cursor_o));

  // top compare with bit 0 forced equal: at the even vpos of 2 the top edge grows one row downward
  raster_cursor_generator #(.TOP_WIDEN(4'h1)) raster_cursor_generator_wide_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .frame_pulse_i(frame_pulse),
    .row_pulse_i(row_pulse), .dot_tick_i(dot_tick), .vpos_i(vpos), .hpos_i(hpos),
    .vsize_i(vsize), .hsize_i(hsize), .sel_outline_i(sel[0]), .sel_crosshair_i(sel[1]),
    .sel_fill_i(sel[2]), .cursor_o(cursor_wide));

  function automatic logic want_bit(int r, int k, case_type c);
    logic vw, hw, edges, hx, vx;
    vw = (r >= c.vp) && (r <= c.vp + c.vs);
    hw = (k >= c.hp) && (k <= c.hp + c.hs);
    edges = (r == c.vp) || (r == c.vp + c.vs) || (k == c.hp) || (k == c.hp + c.hs);
    hx = (r == c.vp + (c.vs >> 1));
    vx = (k == c.hp + (c.hs >> 1));
    return vw && hw && ((c.sel[0] && edges) || (c.sel[1] && (hx || vx)) || c.sel[2]);
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic run_frame(case_type c);
    int n;
    cur = c;
    vpos = c.vp[POS_W-1:0];
    hpos = c.hp[POS_W-1:0];
    vsize = c.vs[VSIZE_W-1:0];
    hsize = c.hs[HSIZE_W-1:0];
    sel = c.sel;
    rows = 10'(c.vp + c.vs + 2);
    lit = 0;
    lit_wide = 0;
    @(negedge sys_clk_i);
    start = 1'b1;
    @(negedge sys_clk_i);
    start = 1'b0;
    n = 0;
    while (busy && n < 20000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      end_of_test();
    end
  endtask

  // every settled dot while checking is set against the shape the settings ask for
  always @(posedge sys_clk_i) begin
    if (probe && checking && !rst_i) begin
      check(32'(cursor_o), 32'(want_bit(row_n, dot_n, cur)));
      if (cursor_o === 1'b1) lit++;
      if (cursor_wide === 1'b1) lit_wide++;
    end
  end

  initial begin
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    foreach (table_rows[i]) begin
      run_frame(table_rows[i]);
      check(32'(lit), 32'(table_rows[i].lit));
      if (i < 2) check(32'(lit_wide), 32'(wide_lit[i]));
    end
    fork
      run_frame(table_rows[0]);
      begin
        repeat (55) @(negedge sys_clk_i);
        checking = 1'b0;
        rst_i = 1'b1;
        repeat (3) begin
          @(negedge sys_clk_i);
          check(32'(cursor_o), 32'h0);
        end
        rst_i = 1'b0;
      end
    join
    checking = 1'b1;
    run_frame(table_rows[0]);
    check(32'(lit), 32'(table_rows[0].lit));
    end_of_test();
  end
endmodule // raster_cursor_generator_test
